// ==== rtl/tpf_top.sv ====
// How it works
// - near-full flags sync to writer clock, using offsets one and two.
// - near-full low at count >= depth-Y, high at count <= depth-(Y+1).
// - word moved to an output register no longer counts as stored.
// - after a read drops the count, flag rises on second writer edge.
// - an edge too close to the read does not count as first.
// - offsets load preset at reset, in parallel from port A, or serially.
// - two 18-bit mailboxes, A to B and C to A, bypass the queues.
// - mail select steers each transfer between mailbox and queue.
// - port A mailbox write stores A0-A17, or A0-A8 in byte mode.
// - port C mailbox write stores C0-C17, or C0-C8 in byte mode.
// - mailbox write drops its flag; further writes ignored while low.
// - port B mailbox read raises mail one flag, data on B lanes.
// - port A mailbox read raises mail two flag, data on A18 upward.
// - reads keep mailbox contents; endian never reorders mailbox data.
// - port B and port C widths chosen independently by level pins.
// - widths and endian take effect when master reset ends.
// - endian latched at master reset rise, applies to B and C.
// - queues store only 36-bit words; matching on the narrow sides.
// - mailbox lanes outside the selected width are ignored or zero.
// - narrow port C chunks gather; last chunk commits the long word.
`timescale 1ns/100ps
module tpf_top #(
  parameter int DEPTH = tpf_pkg::DEPTH_DEF,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [7:0]             wb_adr_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic [31:0]            wb_dat_i,
  output logic      [31:0]            wb_dat_o,
  output logic                        wb_ack_o,
  input  wire logic                   port_a_clock_i,
  input  wire logic                   port_a_chip_select_n_i,
  input  wire logic                   port_a_direction_i,
  input  wire logic                   port_a_strobe_on_i,
  input  wire logic                   port_a_mail_select_i,
  input  wire logic [tpf_pkg::LW-1:0] port_a_data_i,
  output logic      [tpf_pkg::LW-1:0] port_a_data_o,
  output logic                        port_a_data_oe_o,
  input  wire logic                   port_b_clock_i,
  input  wire logic                   port_b_chip_select_n_i,
  input  wire logic                   port_b_read_strobe_i,
  input  wire logic                   port_b_mail_select_i,
  input  wire logic                   port_b_width_select_i,
  output logic      [tpf_pkg::WW-1:0] port_b_data_o,
  input  wire logic                   port_c_clock_i,
  input  wire logic                   port_c_write_strobe_i,
  input  wire logic                   port_c_mail_select_i,
  input  wire logic                   port_c_width_select_i,
  input  wire logic [tpf_pkg::WW-1:0] port_c_data_i,
  input  wire logic                   endian_order_select_i,
  input  wire logic                   fifo1_full_reset_n_i,
  input  wire logic                   fifo2_full_reset_n_i,
  input  wire logic                   offset_serial_data_i,
  input  wire logic                   offset_serial_en_i,
  input  wire logic                   offset_parallel_en_i,
  output logic                        port_a_near_full_flag_o,
  output logic                        port_c_near_full_flag_o,
  output logic                        port_a_space_flag_o,
  output logic                        port_c_space_flag_o,
  output logic                        mail_one_full_flag_o,
  output logic                        mail_two_full_flag_o
);

  localparam int LW = tpf_pkg::LW;
  localparam int WW = tpf_pkg::WW;
  localparam int BW = tpf_pkg::BW;
  localparam int SW = 20 + LW + WW;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchroniser: two flops, only the second stage is used
  logic [SW-1:0] pin_raw, pin_s1, pin_s2;
  logic a_clk, a_csn, a_dir, a_stb, a_mail;
  logic b_clk, b_csn, b_ren, b_mail, b_width;
  logic c_clk, c_wen, c_mail, c_width;
  logic endian_s, fifo1_full_reset, fifo2_full_reset, ser_d, ser_en, par_en;
  logic [LW-1:0] a_data;
  logic [WW-1:0] c_data;

  assign pin_raw = {port_a_clock_i, port_a_chip_select_n_i, port_a_direction_i,
                    port_a_strobe_on_i, port_a_mail_select_i, port_b_clock_i,
                    port_b_chip_select_n_i, port_b_read_strobe_i,
                    port_b_mail_select_i, port_b_width_select_i,
                    port_c_clock_i, port_c_write_strobe_i,
                    port_c_mail_select_i, port_c_width_select_i,
                    endian_order_select_i, fifo1_full_reset_n_i,
                    fifo2_full_reset_n_i, offset_serial_data_i,
                    offset_serial_en_i, offset_parallel_en_i,
                    port_a_data_i, port_c_data_i};
  assign {a_clk, a_csn, a_dir, a_stb, a_mail, b_clk, b_csn, b_ren, b_mail,
          b_width, c_clk, c_wen, c_mail, c_width, endian_s, fifo1_full_reset, fifo2_full_reset,
          ser_d, ser_en, par_en, a_data, c_data} = pin_s2;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // chunk index of a narrow transfer inside a long word
  function automatic logic [1:0] chunk_idx(input logic byte_m,
                                           input logic big,
                                           input logic [1:0] k);
    logic [1:0] last;
    last = byte_m ? tpf_pkg::LAST_BYTE : tpf_pkg::LAST_WORD;
    chunk_idx = big ? last - k : k;
  endfunction

  function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                             input logic [31:0] d,
                                             input logic [3:0]  sel);
    lane_merge = old;
    if (sel[0]) lane_merge[7:0] = d[7:0];
    if (sel[1]) lane_merge[15:8] = d[15:8];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic [2:0]    clk_prev;
  logic [1:0]    mrs_prev;
  logic          mail_one_full_flag, mail_two_full_flag, big, byte_b, byte_c, prog_sel, ack;
  logic [WW-1:0] a_to_b_bypass_register, c_to_a_bypass_register, b_chunk, b_out;
  logic [LW-1:0] b_hold, c_asm, a_hold, a_out;
  logic [1:0]    b_lane, c_lane;
  logic [AW-1:0] y1, y2;
  logic          a_oe;
  logic [31:0]   dat;

  logic          next_mail_one_full_flag, next_mail_two_full_flag, next_big, next_byte_b, next_byte_c;
  logic          next_prog_sel, next_ack, next_a_oe;
  logic [WW-1:0] next_a_to_b_bypass_register, next_c_to_a_bypass_register, next_b_chunk, next_b_out;
  logic [LW-1:0] next_b_hold, next_c_asm, next_a_hold, next_a_out;
  logic [1:0]    next_b_lane, next_c_lane;
  logic [AW-1:0] next_y1, next_y2;
  logic [31:0]   next_dat;

  // events
  logic ea, eb, ec, a_wr, a_rd, a_mb_wr, a_mb_rd, f1_wr, f2_rd;
  logic b_rd, b_mb_rd, b_f_rd, f1_pop, c_wr, c_mb_wr, c_f_wr, c_last, f2_wr;
  logic wb_req, wb_wr;
  logic f1_empty, f2_empty, near_a, near_c, space_a, space_c;
  logic [LW-1:0] f1_data, f2_data;
  logic [1:0]    ci;

  assign ea = a_clk & ~clk_prev[2];
  assign eb = b_clk & ~clk_prev[1];
  assign ec = c_clk & ~clk_prev[0];

  assign a_wr    = ea & ~a_csn & a_stb & a_dir;
  assign a_rd    = ea & ~a_csn & a_stb & ~a_dir;
  assign a_mb_wr = a_wr & a_mail & mail_one_full_flag & fifo1_full_reset;
  assign a_mb_rd = a_rd & a_mail & fifo2_full_reset;
  assign f1_wr   = a_wr & ~a_mail & ~par_en & fifo1_full_reset;
  assign f2_rd   = a_rd & ~a_mail & ~f2_empty & fifo2_full_reset;
  assign b_rd    = eb & ~b_csn & b_ren;
  assign b_mb_rd = b_rd & b_mail & fifo1_full_reset;
  assign b_f_rd  = b_rd & ~b_mail & fifo1_full_reset;
  assign f1_pop  = b_f_rd & (b_lane == '0) & ~f1_empty;
  // port c is idle while its reset holds; mail select is kept high then
  assign c_wr    = ec & c_wen & fifo2_full_reset;
  assign c_mb_wr = c_wr & c_mail & mail_two_full_flag;
  assign c_f_wr  = c_wr & ~c_mail & space_c;
  assign c_last  = c_lane == (byte_c ? tpf_pkg::LAST_BYTE
                                     : tpf_pkg::LAST_WORD);
  assign f2_wr   = c_f_wr & c_last;
  assign ci      = chunk_idx(byte_c, big, c_lane);

  assign wb_req = wb_cyc_i & wb_stb_i & ~ack;
  assign wb_wr  = wb_req & wb_we_i;

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    next_mail_one_full_flag     = mail_one_full_flag;
    next_mail_two_full_flag     = mail_two_full_flag;
    next_a_to_b_bypass_register    = a_to_b_bypass_register;
    next_c_to_a_bypass_register    = c_to_a_bypass_register;
    next_big      = big;
    next_byte_b   = byte_b;
    next_byte_c   = byte_c;
    next_prog_sel = prog_sel;
    next_y1       = y1;
    next_y2       = y2;
    next_b_hold   = b_hold;
    next_b_chunk  = b_chunk;
    next_b_lane   = b_lane;
    next_c_asm    = c_asm;
    next_c_lane   = c_lane;
    next_a_hold   = a_hold;

    // mailboxes; a write on a full box is already masked off
    if (b_mb_rd) next_mail_one_full_flag = 1'b1;
    if (a_mb_wr) begin
      next_mail_one_full_flag  = 1'b0;
      next_a_to_b_bypass_register = byte_b ? {{BW{1'b0}}, a_data[BW-1:0]}
                          : a_data[WW-1:0];
    end
    if (a_mb_rd) next_mail_two_full_flag = 1'b1;
    if (c_mb_wr) begin
      next_mail_two_full_flag  = 1'b0;
      next_c_to_a_bypass_register = byte_c ? {{BW{1'b0}}, c_data[BW-1:0]}
                          : c_data;
    end

    // offsets: serial shift, parallel load in pairs, bus write
    if (ser_en && ea) begin
      next_y1 = {y1[AW-2:0], y2[AW-1]};
      next_y2 = {y2[AW-2:0], ser_d};
    end else if (par_en && a_wr && !a_mail) begin
      if (prog_sel) next_y2 = a_data[AW-1:0];
      else next_y1 = a_data[AW-1:0];
      next_prog_sel = ~prog_sel;
    end
    if (wb_wr && wb_adr_i == tpf_pkg::ADR_OFS1) begin
      next_y1 = AW'(lane_merge(16'(y1), wb_dat_i, wb_sel_i));
    end
    if (wb_wr && wb_adr_i == tpf_pkg::ADR_OFS2) begin
      next_y2 = AW'(lane_merge(16'(y2), wb_dat_i, wb_sel_i));
    end

    // port b: a pop moves the long word out of the counted memory
    if (f1_pop) begin
      next_b_hold  = f1_data;
      next_b_chunk = byte_b
        ? {{BW{1'b0}}, f1_data[chunk_idx(byte_b, big, 2'h0)*BW +: BW]}
        : f1_data[chunk_idx(byte_b, big, 2'h0)*WW +: WW];
      next_b_lane  = 2'h1;
    end else if (b_f_rd && b_lane != '0) begin
      next_b_chunk = byte_b
        ? {{BW{1'b0}}, b_hold[chunk_idx(byte_b, big, b_lane)*BW +: BW]}
        : b_hold[chunk_idx(byte_b, big, b_lane)*WW +: WW];
      next_b_lane  = (b_lane == (byte_b ? tpf_pkg::LAST_BYTE
                                        : tpf_pkg::LAST_WORD))
                     ? 2'h0 : b_lane + 2'h1;
    end

    // port c: gather chunks, last one commits
    if (c_f_wr) begin
      if (byte_c) next_c_asm[ci*BW +: BW] = c_data[BW-1:0];
      else next_c_asm[ci[0]*WW +: WW] = c_data;
      next_c_lane = c_last ? 2'h0 : c_lane + 2'h1;
    end

    if (f2_rd) next_a_hold = f2_data;

    // width and endian take effect as master reset ends
    if (fifo1_full_reset && !mrs_prev[1]) begin
      next_big    = endian_s;
      next_byte_b = b_width;
    end
    if (fifo2_full_reset && !mrs_prev[0]) begin
      next_big    = endian_s;
      next_byte_c = c_width;
    end

    if (!fifo1_full_reset) begin
      next_mail_one_full_flag     = 1'b1;
      next_y1       = tpf_pkg::OFFSET_PRESET[AW-1:0];
      next_b_lane   = '0;
      next_prog_sel = 1'b0;
    end
    if (!fifo2_full_reset) begin
      next_mail_two_full_flag   = 1'b1;
      next_y2     = tpf_pkg::OFFSET_PRESET[AW-1:0];
      next_c_lane = '0;
    end

    // mailbox data goes out unordered by endian
    next_a_oe  = ~a_csn & ~a_dir;
    next_a_out = a_mail ? {c_to_a_bypass_register, {WW{1'b0}}} : a_hold;
    next_b_out = b_mail ? a_to_b_bypass_register : b_chunk;

    next_ack = wb_cyc_i & wb_stb_i & ~ack;
    next_dat = '0;
    if (wb_req && !wb_we_i) begin
      case (wb_adr_i)
        tpf_pkg::ADR_OFS1: next_dat = 32'(y1);
        tpf_pkg::ADR_OFS2: next_dat = 32'(y2);
        tpf_pkg::ADR_STAT: begin
          next_dat[tpf_pkg::ST_NEAR_A]  = near_a;
          next_dat[tpf_pkg::ST_NEAR_C]  = near_c;
          next_dat[tpf_pkg::ST_MAIL_ONE_FULL_FLAG]    = mail_one_full_flag;
          next_dat[tpf_pkg::ST_MAIL_TWO_FULL_FLAG]    = mail_two_full_flag;
          next_dat[tpf_pkg::ST_SPACE_A] = space_a;
          next_dat[tpf_pkg::ST_SPACE_C] = space_c;
          next_dat[tpf_pkg::ST_BIG]     = big;
          next_dat[tpf_pkg::ST_BYTE_B]  = byte_b;
          next_dat[tpf_pkg::ST_BYTE_C]  = byte_c;
        end
        default: next_dat = '0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_prev <= '0;
      mrs_prev <= '0;
      mail_one_full_flag     <= 1'b1;
      mail_two_full_flag     <= 1'b1;
      a_to_b_bypass_register    <= '0;
      c_to_a_bypass_register    <= '0;
      big      <= 1'b0;
      byte_b   <= 1'b0;
      byte_c   <= 1'b0;
      prog_sel <= 1'b0;
      y1       <= tpf_pkg::OFFSET_PRESET[AW-1:0];
      y2       <= tpf_pkg::OFFSET_PRESET[AW-1:0];
      b_hold   <= '0;
      b_chunk  <= '0;
      b_lane   <= '0;
      c_asm    <= '0;
      c_lane   <= '0;
      a_hold   <= '0;
      a_out    <= '0;
      a_oe     <= 1'b0;
      b_out    <= '0;
      ack      <= 1'b0;
      dat      <= '0;
    end else begin
      clk_prev <= {a_clk, b_clk, c_clk};
      mrs_prev <= {fifo1_full_reset, fifo2_full_reset};
      mail_one_full_flag     <= next_mail_one_full_flag;
      mail_two_full_flag     <= next_mail_two_full_flag;
      a_to_b_bypass_register    <= next_a_to_b_bypass_register;
      c_to_a_bypass_register    <= next_c_to_a_bypass_register;
      big      <= next_big;
      byte_b   <= next_byte_b;
      byte_c   <= next_byte_c;
      prog_sel <= next_prog_sel;
      y1       <= next_y1;
      y2       <= next_y2;
      b_hold   <= next_b_hold;
      b_chunk  <= next_b_chunk;
      b_lane   <= next_b_lane;
      c_asm    <= next_c_asm;
      c_lane   <= next_c_lane;
      a_hold   <= next_a_hold;
      a_out    <= next_a_out;
      a_oe     <= next_a_oe;
      b_out    <= next_b_out;
      ack      <= next_ack;
      dat      <= next_dat;
    end
  end

  assign wb_ack_o             = ack;
  assign wb_dat_o             = dat;
  assign port_a_data_o        = a_out;
  assign port_a_data_oe_o     = a_oe;
  assign port_b_data_o        = b_out;
  assign mail_one_full_flag_o = mail_one_full_flag;
  assign mail_two_full_flag_o = mail_two_full_flag;

  ////////////////////////////////////////////////////////////////////////////
  // queues: port a feeds queue one, port c feeds queue two
  tpf_fifo #(.DEPTH(DEPTH), .AW(AW)) u_fifo1 (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .clear_i     (~fifo1_full_reset),
    .wr_en_i     (f1_wr),
    .wr_data_i   (a_data),
    .rd_en_i     (f1_pop),
    .rd_data_o   (f1_data),
    .empty_o     (f1_empty),
    .wr_edge_i   (ea),
    .offset_i    (y1),
    .near_full_o (near_a),
    .space_o     (space_a)
  );

  tpf_fifo #(.DEPTH(DEPTH), .AW(AW)) u_fifo2 (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .clear_i     (~fifo2_full_reset),
    .wr_en_i     (f2_wr),
    .wr_data_i   (next_c_asm),
    .rd_en_i     (f2_rd),
    .rd_data_o   (f2_data),
    .empty_o     (f2_empty),
    .wr_edge_i   (ec),
    .offset_i    (y2),
    .near_full_o (near_c),
    .space_o     (space_c)
  );

  assign port_a_near_full_flag_o = near_a;
  assign port_c_near_full_flag_o = near_c;
  assign port_a_space_flag_o     = space_a;
  assign port_c_space_flag_o     = space_c;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_mrs_rise;
    fifo1_full_reset && !mrs_prev[1];
  endsequence

  property p_mb1_block;
    (!mail_one_full_flag && a_wr && a_mail && !b_mb_rd && fifo1_full_reset)
      |=> $stable(a_to_b_bypass_register) && !mail_one_full_flag;
  endproperty
  a_mb1_block: assert property (p_mb1_block)
    else $error("write to full mailbox one not ignored");

  property p_mb1_low;
    a_mb_wr |=> !mail_one_full_flag_o;
  endproperty
  a_mb1_low: assert property (p_mb1_low)
    else $error("mailbox one flag not low after write");

  property p_mb1_data;
    (a_mb_wr && !byte_b) |=> a_to_b_bypass_register == $past(a_data[WW-1:0]);
  endproperty
  a_mb1_data: assert property (p_mb1_data)
    else $error("mailbox one word not stored");

  property p_mb1_read;
    (b_mb_rd && !a_mb_wr && fifo1_full_reset) |=> mail_one_full_flag_o && $stable(a_to_b_bypass_register);
  endproperty
  a_mb1_read: assert property (p_mb1_read)
    else $error("mailbox one read wrong");

  property p_mb2_read;
    (a_mb_rd && !c_mb_wr) |=> mail_two_full_flag_o && $stable(c_to_a_bypass_register);
  endproperty
  a_mb2_read: assert property (p_mb2_read)
    else $error("mailbox two read wrong");

  property p_mb2_byte;
    (c_mb_wr && byte_c) |=> c_to_a_bypass_register == {{BW{1'b0}}, $past(c_data[BW-1:0])};
  endproperty
  a_mb2_byte: assert property (p_mb2_byte)
    else $error("mailbox two byte not stored");

  property p_b_mail_out;
    b_mail |=> port_b_data_o == $past(a_to_b_bypass_register);
  endproperty
  a_b_mail_out: assert property (p_b_mail_out)
    else $error("port b does not show mailbox one");

  property p_endian;
    s_mrs_rise |=> big == $past(endian_s) && byte_b == $past(b_width);
  endproperty
  a_endian: assert property (p_endian)
    else $error("endian or width not latched at reset end");

endmodule // tpf_top

// ==== rtl/tpf_pkg.sv ====
package tpf_pkg;

  // memory shape
  localparam int DEPTH_DEF = 2048;
  localparam int LW        = 36;
  localparam int WW        = 18;
  localparam int BW        = 9;

  // offset loaded into both near-full offsets at master reset
  localparam logic [15:0] OFFSET_PRESET = 16'h0008;

  // narrow-port chunk index of the last chunk of a long word
  localparam logic [1:0] LAST_WORD = 2'h1;
  localparam logic [1:0] LAST_BYTE = 2'h3;

  // wishbone register byte addresses
  localparam logic [7:0] ADR_OFS1 = 8'h00;
  localparam logic [7:0] ADR_OFS2 = 8'h04;
  localparam logic [7:0] ADR_STAT = 8'h08;

  // status register bit positions
  localparam int ST_NEAR_A  = 0;
  localparam int ST_NEAR_C  = 1;
  localparam int ST_MAIL_ONE_FULL_FLAG    = 2;
  localparam int ST_MAIL_TWO_FULL_FLAG    = 3;
  localparam int ST_SPACE_A = 4;
  localparam int ST_SPACE_C = 5;
  localparam int ST_BIG     = 6;
  localparam int ST_BYTE_B  = 7;
  localparam int ST_BYTE_C  = 8;

endpackage

// ==== rtl/tpf_fifo.sv ====
`timescale 1ns/100ps
module tpf_fifo #(
  parameter int DEPTH = tpf_pkg::DEPTH_DEF,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   clear_i,
  input  wire logic                   wr_en_i,
  input  wire logic [tpf_pkg::LW-1:0] wr_data_i,
  input  wire logic                   rd_en_i,
  output logic      [tpf_pkg::LW-1:0] rd_data_o,
  output logic                        empty_o,
  input  wire logic                   wr_edge_i,
  input  wire logic [AW-1:0]          offset_i,
  output logic                        near_full_o,
  output logic                        space_o
);

  logic [tpf_pkg::LW-1:0] mem [DEPTH];
  logic [AW-1:0]          wptr, rptr, next_wptr, next_rptr;
  logic [AW:0]            count, next_count, thr;
  logic                   near, stage, space;
  logic                   next_near, next_stage, next_space;
  logic                   wr_ok, rd_ok;

  assign rd_data_o   = mem[rptr];
  assign empty_o     = (count == '0);
  assign near_full_o = near;
  assign space_o     = space;
  assign thr = (AW+1)'(DEPTH) - {1'b0, offset_i};

  always_comb begin
    wr_ok      = wr_en_i && (count < (AW+1)'(DEPTH));
    rd_ok      = rd_en_i && (count != '0);
    next_wptr  = wr_ok ? wptr + 1'b1 : wptr;
    next_rptr  = rd_ok ? rptr + 1'b1 : rptr;
    next_count = count + (AW+1)'(wr_ok) - (AW+1)'(rd_ok);
    next_near  = near;
    next_stage = stage;
    if (next_count >= thr) begin
      next_near  = 1'b0;
      next_stage = 1'b0;
    end else if (wr_edge_i) begin
      // a read in the same cycle as this edge is not yet seen here
      next_stage = (count < thr);
      next_near  = near | stage;
    end
    next_space = (next_count < (AW+1)'(DEPTH));
    if (clear_i) begin
      next_wptr  = '0;
      next_rptr  = '0;
      next_count = '0;
      next_near  = 1'b1;
      next_stage = 1'b0;
      next_space = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wptr  <= '0;
      rptr  <= '0;
      count <= '0;
      near  <= 1'b1;
      stage <= 1'b0;
      space <= 1'b0;
    end else begin
      wptr  <= next_wptr;
      rptr  <= next_rptr;
      count <= next_count;
      near  <= next_near;
      stage <= next_stage;
      space <= next_space;
    end
  end

  always_ff @(posedge clk_i) begin
    if (wr_ok && !clear_i) begin
      mem[wptr] <= wr_data_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_first_edge;
    wr_edge_i && !near && !stage && !clear_i && (next_count < thr);
  endsequence

  property p_near_low;
    (!clear_i && next_count >= thr) |=> !near_full_o;
  endproperty
  a_near_low: assert property (p_near_low)
    else $error("near-full flag not low at threshold");

  property p_near_wait;
    s_first_edge |=> !near_full_o;
  endproperty
  a_near_wait: assert property (p_near_wait)
    else $error("near-full flag rose on first sync edge");

  property p_near_high;
    (wr_edge_i && stage && !clear_i && next_count < thr) |=> near_full_o;
  endproperty
  a_near_high: assert property (p_near_high)
    else $error("near-full flag not high on second sync edge");

endmodule // tpf_fifo

// ==== test/tpf_port_master.sv ====
`timescale 1ns/100ps
module tpf_port_master (
  input  wire logic       clk_i,
  output logic      [2:0] port_clock_o
);
  initial port_clock_o = 3'h0;
  // one slow rising edge on port p; the clock stands still otherwise
  task automatic pulse(input int p);
    repeat (4) @(posedge clk_i);
    port_clock_o[p] <= 1'b1;
    repeat (4) @(posedge clk_i);
    port_clock_o[p] <= 1'b0;
    repeat (5) @(posedge clk_i);
  endtask
endmodule // tpf_port_master

// ==== test/tb.sv ====
`timescale 1ns/100ps
module tb;
  logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'h3;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic wb_stb_i, wb_ack_o, port_a_data_oe_o;
  logic port_a_chip_select_n_i = 1'b1, port_a_direction_i = 1'b0;
  logic port_a_strobe_on_i = 1'b0, port_a_mail_select_i = 1'b0;
  logic port_b_chip_select_n_i = 1'b1, port_b_read_strobe_i = 1'b0;
  logic port_b_mail_select_i = 1'b0, port_b_width_select_i = 1'b0;
  logic port_c_write_strobe_i = 1'b0, port_c_mail_select_i = 1'b1;
  logic port_c_width_select_i = 1'b0, endian_order_select_i = 1'b1;
  logic fifo1_full_reset_n_i = 1'b0, fifo2_full_reset_n_i = 1'b0;
  logic offset_serial_data_i = 1'b0, offset_serial_en_i = 1'b0;
  logic offset_parallel_en_i = 1'b0;
  logic [35:0] port_a_data_i = 36'h0, port_a_data_o;
  logic [17:0] port_c_data_i = 18'h0, port_b_data_o;
  logic port_a_near_full_flag_o, port_c_near_full_flag_o;
  logic port_a_space_flag_o, port_c_space_flag_o;
  logic mail_one_full_flag_o, mail_two_full_flag_o;
  logic port_a_clock_i, port_b_clock_i, port_c_clock_i;
  logic [2:0] pclk;
  int failures = 0, samples_checked = 0, cycles = 0;
  assign wb_stb_i = wb_cyc_i;
  assign {port_c_clock_i, port_b_clock_i, port_a_clock_i} = pclk;
  tpf_top #(.DEPTH(16)) tpf_top_i (.*);
  tpf_port_master agent (.clk_i(clk_i), .port_clock_o(pclk));
  initial forever #4 clk_i = ~clk_i;
  task automatic check(string n, logic [35:0] s, logic [35:0] e);
    samples_checked++;
    if (s !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wb(logic w, logic [7:0] a, logic [31:0] d,
                    logic [3:0] s = 4'h3);
    @(posedge clk_i);
    {wb_cyc_i, wb_we_i, wb_sel_i, wb_adr_i, wb_dat_i} <= {1'b1, w, s, a, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    {wb_cyc_i, wb_we_i} <= 2'b00;
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin failures++; conclude(); end
  end
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    {fifo1_full_reset_n_i, fifo2_full_reset_n_i} <= 2'b11;
    repeat (8) @(posedge clk_i);
    port_c_mail_select_i <= 1'b0;
    wb(0, 8'h00, 0); check("ofs1", q, 36'h8);
    wb(0, 8'h08, 0); check("stat", q, 36'h7f);
    wb(1, 8'h04, 5); wb(0, 8'h04, 0); check("ofs2", q, 36'h5);
    wb(0, 8'hfc, 0); check("unmapped", q, 36'h0);
    $display("test config done");
    {port_a_chip_select_n_i, port_a_direction_i} <= 2'b01;
    port_a_strobe_on_i <= 1'b1;
    for (int i = 1; i <= 8; i++) begin
      port_a_data_i <= 36'(i);
      agent.pulse(0);
      check("near_a", port_a_near_full_flag_o, 36'(i < 8));
    end
    port_a_mail_select_i <= 1'b1;
    port_a_data_i <= 36'hf_ff01_2345;
    agent.pulse(0); check("mail_one_full_flag", mail_one_full_flag_o, 0);
    port_a_data_i <= 36'h0_0000_0abc;
    agent.pulse(0);
    {port_b_chip_select_n_i, port_b_read_strobe_i} <= 2'b01;
    port_b_mail_select_i <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      agent.pulse(1);
      check("mail_one_full_flag_rd", mail_one_full_flag_o, 1);
      check("a_to_b_bypass_register", port_b_data_o, 36'h1_2345);
    end
    $display("test a_to_b_bypass_register done");
    {port_c_write_strobe_i, port_c_mail_select_i} <= 2'b11;
    port_c_data_i <= 18'h2a5a5;
    agent.pulse(2); check("mail_two_full_flag", mail_two_full_flag_o, 0);
    {port_c_write_strobe_i, port_a_direction_i} <= 2'b00;
    agent.pulse(0);
    check("mail_two_full_flag_rd", mail_two_full_flag_o, 1);
    check("c_to_a_bypass_register", port_a_data_o[35:18], 36'h2a5a5);
    check("oe", port_a_data_oe_o, 1);
    $display("test c_to_a_bypass_register done");
    {port_c_write_strobe_i, port_c_mail_select_i} <= 2'b10;
    port_c_data_i <= 18'h11111;
    agent.pulse(2);
    port_c_data_i <= 18'h22222;
    agent.pulse(2);
    {port_c_write_strobe_i, port_a_mail_select_i} <= 2'b00;
    agent.pulse(0);
    check("fifo2", port_a_data_o, {18'h11111, 18'h22222});
    $display("test fifo2 done");
    {fifo1_full_reset_n_i, fifo2_full_reset_n_i} <= 2'b00;
    {endian_order_select_i, port_c_mail_select_i} <= 2'b01;
    {port_b_width_select_i, port_c_width_select_i} <= 2'b11;
    repeat (8) @(posedge clk_i);
    check("space_rst", {port_a_space_flag_o, port_c_space_flag_o}, 0);
    {fifo1_full_reset_n_i, fifo2_full_reset_n_i} <= 2'b11;
    repeat (8) @(posedge clk_i);
    check("space", {port_a_space_flag_o, port_c_space_flag_o}, 3);
    check("near_c", port_c_near_full_flag_o, 1);
    wb(0, 8'h08, 0);
    check("stat2", q, 36'h1bf);
    {port_a_direction_i, port_a_mail_select_i} <= 2'b10;
    offset_parallel_en_i <= 1'b1;
    port_a_data_i <= 36'h3;
    agent.pulse(0);
    port_a_data_i <= 36'h6;
    agent.pulse(0);
    {port_a_chip_select_n_i, offset_parallel_en_i} <= 2'b10;
    wb(0, 8'h04, 0);
    check("par", q, 36'h6);
    {offset_serial_en_i, offset_serial_data_i} <= 2'b11;
    agent.pulse(0);
    offset_serial_en_i <= 1'b0;
    wb(0, 8'h00, 0);
    check("ser1", q, 36'h6);
    wb(0, 8'h04, 0);
    check("ser2", q, 36'hd);
    wb(1, 8'h00, 32'h9, 4'h2);
    wb(0, 8'h00, 0);
    check("sel", q, 36'h6);
    {port_a_chip_select_n_i, port_a_mail_select_i} <= 2'b01;
    port_a_data_i <= 36'h0_0003_ff55;
    agent.pulse(0);
    agent.pulse(1);
    check("a_to_b_bypass_register_byte", port_b_data_o, 36'h155);
    $display("test reconfig done");
    conclude();
  end
endmodule // tb
